// File: bench/fifo_link_props.sv
// Concurrent checks on the pins between the controller and the FIFO device.
// Assumes one clock, synchronous active-low reset and default offsets.
`timescale 1ns/100ps
module fifo_link_props
  import fifo_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic write_enable_a_n,
  input wire logic write_enable_b_or_load,
  input wire logic read_enable_a_n,
  input wire logic read_enable_b_n,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n
);
  // ----------------------------------------------------------------
  // Word count kept from the pins
  // ----------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic [CNT_W-1:0] words_reg;
  // Only normal-mode transfers count; offset accesses leave the count alone.
  assign wr_go = !write_enable_a_n && write_enable_b_or_load && full_flag_n;
  assign rd_go = !read_enable_a_n && !read_enable_b_n && write_enable_b_or_load && empty_flag_n;
  // The count follows accepted transfers, so a flag slip shows as a mismatch.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      words_reg <= '0;
    end else begin
      words_reg <= words_reg + CNT_W'(wr_go) - CNT_W'(rd_go);
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  a_full_at_depth: assert property (full_flag_n == (words_reg != CNT_W'(DEPTH)))
    else $error("full flag disagrees with word count");
  a_empty_at_zero: assert property (empty_flag_n == (words_reg != '0))
    else $error("empty flag disagrees with word count");
  a_aempty_level: assert property (almost_empty_flag_n == (words_reg > 7))
    else $error("almost empty flag off threshold");
  a_afull_level: assert property (almost_full_flag_n == (words_reg < DEPTH - 7))
    else $error("almost full flag off threshold");
  a_write_blocked: assert property (!full_flag_n && !write_enable_a_n && read_enable_a_n
    |=> !full_flag_n) else $error("write accepted while full");
  a_read_blocked: assert property (!empty_flag_n && !read_enable_a_n && write_enable_a_n
    && write_enable_b_or_load |=> !empty_flag_n && $stable(rdata))
    else $error("read accepted while empty");
  a_reset_flags: assert property ($rose(RSTN_I) |-> !empty_flag_n && full_flag_n
    && !almost_empty_flag_n && almost_full_flag_n) else $error("flags wrong after reset");
  a_full_release: assert property (!full_flag_n && rd_go && write_enable_a_n
    |=> full_flag_n) else $error("full flag stuck after a read");
endmodule // fifo_link_props

// File: bench/tb_sync_fifo_flags_width_expansion.sv
// Bench: an AHB-Lite master drives the controller, which drives the FIFO device.
// Assumes one 200 MHz clock and no other master on the bus.
`timescale 1ns/100ps
module tb_sync_fifo_flags_width_expansion;
  import fifo_pkg::*;
  logic clk;
  logic rstn;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hresp;
  logic irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rv;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  fifo_link_if fifo_link_if_i ();
  fifo_device fifo_device_i (.CLOCK_I(clk), .RSTN_I(rstn), .LINK(fifo_link_if_i));
  fifo_controller fifo_controller_i (.CLOCK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .IRQ_O(irq), .LINK(fifo_link_if_i));
  fifo_link_props fifo_link_props_i (.CLOCK_I(clk), .RSTN_I(rstn),
    .rdata(fifo_link_if_i.rdata), .write_enable_a_n(fifo_link_if_i.write_enable_a_n),
    .write_enable_b_or_load(fifo_link_if_i.write_enable_b_or_load),
    .read_enable_a_n(fifo_link_if_i.read_enable_a_n),
    .read_enable_b_n(fifo_link_if_i.read_enable_b_n),
    .empty_flag_n(fifo_link_if_i.empty_flag_n), .full_flag_n(fifo_link_if_i.full_flag_n),
    .almost_empty_flag_n(fifo_link_if_i.almost_empty_flag_n),
    .almost_full_flag_n(fifo_link_if_i.almost_full_flag_n));
  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The whole run needs about 840 cycles; over twenty times that means a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // An idle cycle first lets flags settle from the last pin strobe before sampling.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  function automatic logic [31:0] flags_for(input int k);
    return {28'h0000000, k <= 7, k >= DEPTH - 7, k == 0, k == DEPTH};
  endfunction
  function automatic logic [31:0] word_for(input int k);
    return 32'((k * 37 + 5) % 512);
  endfunction
  task automatic irq_after(input logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq", {31'h00000000, irq}, {31'h00000000, exp});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset left the load pin low, so WDATA and RDATA reach the offset registers.
  task automatic t_offsets;
    bus(1'b1, WDATA_OFFSET, {26'h0000000, EMPTY_OFFSET_RESET});
    bus(1'b0, RDATA_OFFSET, 32'h00000000);
    check("offset first", rv, 32'h00000000);
    bus(1'b0, RDATA_OFFSET, 32'h00000000);
    check("empty offset", rv, {26'h0000000, EMPTY_OFFSET_RESET});
    bus(1'b0, STATUS_OFFSET, 32'h00000000);
    check("status load", rv, flags_for(0));
    $display("test offsets done");
  endtask
  task automatic t_fill;
    bus(1'b1, STATUS_OFFSET, 32'h00000000);
    bus(1'b0, STATUS_OFFSET, 32'h00000000);
    check("status reset", rv, flags_for(0));
    bus(1'b1, CTRL_OFFSET, 32'h00000002);
    for (int k = 1; k <= DEPTH; k++) begin
      bus(1'b1, WDATA_OFFSET, word_for(k - 1));
      bus(1'b0, STATUS_OFFSET, 32'h00000000);
      check("status fill", rv, flags_for(k));
    end
    bus(1'b1, WDATA_OFFSET, 32'h000001AA);
    bus(1'b0, STATUS_OFFSET, 32'h00000000);
    check("status overfill", rv, flags_for(DEPTH));
    $display("test fill done");
  endtask
  task automatic t_irq;
    irq_after(1'b0);
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h00000000);
    check("irq full bit", rv >> IRQ_FULL_BIT & 32'h1, 32'h00000001);
    bus(1'b1, IRQ_MASK_OFFSET, 32'h00000001 << IRQ_FULL_BIT);
    irq_after(1'b1);
    bus(1'b1, IRQ_STATUS_OFFSET, 32'h00000001 << IRQ_FULL_BIT);
    irq_after(1'b0);
    $display("test irq done");
  endtask
  task automatic t_drain;
    for (int k = 0; k < DEPTH; k++) begin
      bus(1'b0, RDATA_OFFSET, 32'h00000000);
      check("word", rv, k == 0 ? 32'h00000000 : word_for(k - 1));
      bus(1'b0, STATUS_OFFSET, 32'h00000000);
      check("status drain", rv, flags_for(DEPTH - 1 - k));
    end
    repeat (2) begin
      bus(1'b0, RDATA_OFFSET, 32'h00000000);
      check("word empty", rv, word_for(DEPTH - 1));
    end
    bus(1'b0, STATUS_OFFSET, 32'h00000000);
    check("status empty", rv, flags_for(0));
    $display("test drain done");
  endtask
  task automatic t_unmapped;
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h00000000);
    check("unmapped", rv, 32'h00000000);
    bus(1'b0, CTRL_OFFSET, 32'h00000000);
    check("ctrl", rv, 32'h00000002);
    $display("test unmapped done");
  endtask
  initial begin
    rstn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_offsets();
    t_fill();
    t_irq();
    t_drain();
    t_unmapped();
    results();
  end
endmodule // tb_sync_fifo_flags_width_expansion

// File: common/fifo_link_if.sv
// Pin bundle between the flagged FIFO and the logic that drives it.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface fifo_link_if;
  import fifo_pkg::*;
  logic [DATA_W-1:0] wdata;
  logic write_enable_a_n;
  logic write_enable_b_or_load;
  logic read_enable_a_n;
  logic read_enable_b_n;
  logic [DATA_W-1:0] rdata;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;
  modport device (
    input wdata, write_enable_a_n, write_enable_b_or_load, read_enable_a_n,
    read_enable_b_n,
    output rdata, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n
  );
  modport system (
    output wdata, write_enable_a_n, write_enable_b_or_load, read_enable_a_n,
    read_enable_b_n,
    input rdata, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n
  );
endinterface

// File: common/fifo_pkg.sv
// Package for the flagged synchronous FIFO and its controller.
// Assumes one clock for both ports and a synchronous active-low reset.
package fifo_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 7;
  localparam int OFFSET_W = 6;
  // ----------------------------------------------------------------
  // Offset defaults
  // ----------------------------------------------------------------
  localparam logic [OFFSET_W-1:0] EMPTY_OFFSET_RESET = 6'h07;
  localparam logic [OFFSET_W-1:0] FULL_OFFSET_RESET = 6'h07;
  // ----------------------------------------------------------------
  // Controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] WDATA_OFFSET = 8'h08;
  localparam logic [7:0] RDATA_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;
  // Control fields.
  localparam int CTRL_LOAD_MODE_BIT = 0;
  localparam int CTRL_LOAD_LEVEL_BIT = 1;
  // Interrupt fields.
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_EMPTY_BIT = 1;
  localparam int IRQ_AFULL_BIT = 2;
  localparam int IRQ_AEMPTY_BIT = 3;
  localparam int IRQ_W = 4;
endpackage

// File: core/fifo_controller.sv
// System-side controller driving the FIFO pins from AHB-Lite registers.
// Assumes one FIFO link on the same clock; widened groups AND the flags.
`timescale 1ns/100ps
module fifo_controller
  import fifo_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic IRQ_O,
  fifo_link_if.system LINK
);
  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [1:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic wen_reg;
  logic ren_reg;
  logic [31:0] hrdata_reg;
  logic irq_reg;
  logic [IRQ_W-1:0] flag_prev_reg;
  logic [IRQ_W-1:0] flag_now;
  logic [IRQ_W-1:0] irq_set;
  logic wr_phase;

  // One device on the link: the AND of a single active-low line is that line,
  // so its own empty and full flags are the composite ones.
  // The almost flags may be taken from any one device of a group.
  assign flag_now = {!LINK.almost_empty_flag_n, !LINK.almost_full_flag_n,
                     !LINK.empty_flag_n, !LINK.full_flag_n};
  assign irq_set = flag_now & ~flag_prev_reg;
  assign wr_phase = ap_valid_reg && ap_write_reg;

  // Address phase capture; slave always ready, zero wait states.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else if (HREADY_I) begin
      ap_valid_reg <= HSEL_I && HTRANS_I[1];
      ap_write_reg <= HWRITE_I;
      ap_addr_reg <= HADDR_I[7:0];
    end
  end

  // Control and data registers; a write to WDATA issues one pin strobe.
  // Load-pin level is held low in reset so the FIFO enters load mode.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ctrl_reg <= 2'h0;
      wdata_reg <= '0;
      wen_reg <= 1'b0;
      irq_mask_reg <= '0;
    end else begin
      wen_reg <= wr_phase && ap_addr_reg == WDATA_OFFSET;
      if (wr_phase && ap_addr_reg == CTRL_OFFSET) begin
        ctrl_reg <= HWDATA_I[1:0];
      end
      if (wr_phase && ap_addr_reg == WDATA_OFFSET) begin
        wdata_reg <= HWDATA_I[DATA_W-1:0];
      end
      if (wr_phase && ap_addr_reg == IRQ_MASK_OFFSET) begin
        irq_mask_reg <= HWDATA_I[IRQ_W-1:0];
      end
    end
  end

  // Reads: status, and RDATA pops one word through a read strobe.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ren_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      ren_reg <= HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I &&
                 HADDR_I[7:0] == RDATA_OFFSET;
      if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
        unique case (HADDR_I[7:0])
          CTRL_OFFSET: hrdata_reg <= {30'h0, ctrl_reg};
          STATUS_OFFSET: hrdata_reg <= {28'h0, flag_now};
          RDATA_OFFSET: hrdata_reg <= {23'h0, LINK.rdata};
          IRQ_STATUS_OFFSET: hrdata_reg <= {28'h0, irq_stat_reg};
          IRQ_MASK_OFFSET: hrdata_reg <= {28'h0, irq_mask_reg};
          default: hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      irq_stat_reg <= '0;
      flag_prev_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      flag_prev_reg <= flag_now;
      if (wr_phase && ap_addr_reg == IRQ_STATUS_OFFSET) begin
        irq_stat_reg <= (irq_stat_reg & ~HWDATA_I[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Wider words drive every device of a group from these same lines.
  assign LINK.wdata = wdata_reg;
  assign LINK.write_enable_a_n = !wen_reg;
  assign LINK.write_enable_b_or_load = RSTN_I && ctrl_reg[CTRL_LOAD_LEVEL_BIT];
  assign LINK.read_enable_a_n = !ren_reg;
  assign LINK.read_enable_b_n = 1'b0;
  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign IRQ_O = irq_reg;
endmodule // fifo_controller

// File: core/fifo_device.sv
// Synchronous FIFO with empty, full and programmable almost flags.
// Assumes control pins come from logic on CLOCK_I; both ports share it.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
// Summary of operation
// - System widens word by driving devices together.
// - System merges empty and full flags.
// - Almost flags may come from one device.
// - Second read enable may be tied low.
// - System holds load pin low in reset.
// - Full flag low when all locations used.
// - Writes ignored while full flag low.
// - Full flag changes only on write clock.
// - Empty flag low when no words remain.
// - Reads ignored while empty flag low.
// - Empty flag changes only on read clock.
// - All four flags are registered outputs.
// - Almost-empty low at n or fewer words.
// - Almost-full low at depth minus m words.
// - Offsets default to seven words each.
// - Load pin high in reset: second enable.
module fifo_device
  import fifo_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  fifo_link_if.device LINK
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr_reg;
  logic [ADDR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic two_enable_mode_reg;
  logic [OFFSET_W-1:0] empty_offset_reg;
  logic [OFFSET_W-1:0] full_offset_reg;
  logic [1:0] load_sel_reg;
  logic [1:0] read_sel_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic empty_n_reg;
  logic full_n_reg;
  logic aempty_n_reg;
  logic afull_n_reg;
  logic load_mode;
  logic do_write;
  logic do_read;
  logic load_write;
  logic load_read;
  logic [OFFSET_W-1:0] sel_offset;

  // ----------------------------------------------------------------
  // Threshold helpers
  // ----------------------------------------------------------------
  // Both almost flags compare the occupancy that the edge will leave behind.
  // Keeping each compare in one place stops flag and readback drifting apart.
  function automatic logic over_empty_mark(input logic [CNT_W-1:0] words,
                                           input logic [OFFSET_W-1:0] offset);
    return words > CNT_W'(offset);
  endfunction

  // A full offset is at most 63 here, so the subtraction can never wrap.
  function automatic logic under_full_mark(input logic [CNT_W-1:0] words,
                                           input logic [OFFSET_W-1:0] offset);
    return words < CNT_W'(DEPTH) - CNT_W'(offset);
  endfunction

  // ----------------------------------------------------------------
  // Transfer qualification
  // ----------------------------------------------------------------
  // Load mode exists only when the pin was low in reset and is low now.
  assign load_mode = !two_enable_mode_reg && !LINK.write_enable_b_or_load;
  // In both modes a store write needs the first enable low and the pin high:
  // in load-enable mode a high pin simply means normal operation.
  // A full store refuses the write whatever the pins say.
  assign do_write = !LINK.write_enable_a_n && full_n_reg &&
                    LINK.write_enable_b_or_load;
  // An empty store refuses the read, so the last word stays on the outputs.
  assign do_read = !LINK.read_enable_a_n && !LINK.read_enable_b_n && empty_n_reg &&
                   !load_mode;
  // Offset access; a write wins so the two never touch the offsets together.
  assign load_write = load_mode && !LINK.write_enable_a_n;
  assign load_read = load_mode && !LINK.read_enable_a_n && !LINK.read_enable_b_n && !load_write;
  // One clock serves both ports, so a single counter is exact.
  assign count_next = count_reg + CNT_W'(do_write) - CNT_W'(do_read);
  // The readback rotation picks the empty pair first, then the full pair.
  assign sel_offset = read_sel_reg[1] ? full_offset_reg : empty_offset_reg;

  // ----------------------------------------------------------------
  // Pin mode capture
  // ----------------------------------------------------------------
  // The pin mode is caught on every reset edge, so release only freezes it.
  // A pin that moves during reset counts at its level on the last reset edge.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      two_enable_mode_reg <= LINK.write_enable_b_or_load;
    end
  end

  // ----------------------------------------------------------------
  // Word storage
  // ----------------------------------------------------------------
  // No reset is needed for the array: a word is only read after it was written.
  // Leaving it unreset also lets the array map onto plain memory cells.
  always_ff @(posedge CLOCK_I) begin
    if (do_write) begin
      mem[wr_ptr_reg] <= LINK.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  // Pointers wrap at the depth on their own, since the depth is a power of two.
  // The count needs one more bit than a pointer to tell full from empty.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_write) begin
        wr_ptr_reg <= wr_ptr_reg + ADDR_W'(1);
      end
      if (do_read) begin
        rd_ptr_reg <= rd_ptr_reg + ADDR_W'(1);
      end
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // Offset registers
  // ----------------------------------------------------------------
  // Offset registers, loaded low then high byte in rotation.
  // The rotation survives leaving load mode, so a later load takes the next one.
  // Reset, or the wrap after the full high byte, brings it back to the empty low byte.
  // Only six bits matter at this depth; the high byte and the upper bits of the low byte are dropped.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      empty_offset_reg <= EMPTY_OFFSET_RESET;
      full_offset_reg <= FULL_OFFSET_RESET;
      load_sel_reg <= 2'h0;
    end else if (load_write) begin
      load_sel_reg <= load_sel_reg + 2'h1;
      unique case (load_sel_reg)
        2'h0: empty_offset_reg <= LINK.wdata[OFFSET_W-1:0];
        2'h1: empty_offset_reg <= empty_offset_reg;
        2'h2: full_offset_reg <= LINK.wdata[OFFSET_W-1:0];
        2'h3: full_offset_reg <= full_offset_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data path: FIFO words or offset readback.
  // A refused read leaves the register alone, so the last word stays visible.
  // High bytes of the offsets read back as zero at this depth.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rdata_reg <= '0;
      read_sel_reg <= 2'h0;
    end else if (do_read) begin
      rdata_reg <= mem[rd_ptr_reg];
    end else if (load_read) begin
      read_sel_reg <= read_sel_reg + 2'h1;
      rdata_reg <= read_sel_reg[0] ? '0 : DATA_W'(sel_offset);
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Flags, all registered from the next occupancy.
  // Working from the next count keeps each flag exact on the very edge it moves.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      empty_n_reg <= 1'b0;
      full_n_reg <= 1'b1;
      aempty_n_reg <= 1'b0;
      afull_n_reg <= 1'b1;
    end else begin
      full_n_reg <= (count_next != CNT_W'(DEPTH));
      empty_n_reg <= (count_next != '0);
      aempty_n_reg <= over_empty_mark(count_next, empty_offset_reg);
      afull_n_reg <= under_full_mark(count_next, full_offset_reg);
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Every pin output comes straight from a register.
  assign LINK.rdata = rdata_reg;
  assign LINK.empty_flag_n = empty_n_reg;
  assign LINK.full_flag_n = full_n_reg;
  assign LINK.almost_empty_flag_n = aempty_n_reg;
  assign LINK.almost_full_flag_n = afull_n_reg;
endmodule // fifo_device
